/* common/output_driver_divider_regs.svh */
`ifndef OUTPUT_DRIVER_DIVIDER_REGS_SVH
`define OUTPUT_DRIVER_DIVIDER_REGS_SVH

// Register offsets on the byte register port
`define A_OUT_EN       16'h0077
`define A_POLARITY     16'h0078
`define A_STYLE_76     16'h0079
`define A_STYLE_54     16'h007A
`define A_STYLE_32     16'h007B
`define A_STYLE_10     16'h007C
`define A_S1_OUT0      16'h007D
`define A_S2_OUT0_HI   16'h007E
`define A_S2_OUT0_LO   16'h007F
`define A_S1_OUT1      16'h0800
`define A_S2_OUT1_HI   16'h0081
`define A_S2_OUT1_LO   16'h0082
`define A_INT_OUT2_TOP 16'h0083
`define A_INT_OUT2_MID 16'h0084
`define A_INT_OUT2_LOW 16'h0085
`define A_INT_OUT3_TOP 16'h0086
`define A_INT_OUT3_MID 16'h0087
`define A_INT_OUT3_LOW 16'h0088
`define A_S1_OUT4      16'h0089
`define A_S2_OUT4_HI   16'h008A
`define A_S2_OUT4_LO   16'h008B
`define A_S1_OUT5      16'h008C
`define A_S2_OUT5_HI   16'h008D
`define A_S2_OUT5_LO   16'h008E
`define A_S1_OUT6      16'h008F
`define A_S2_OUT6_HI   16'h0090
`define A_S2_OUT6_LO   16'h0091
`define A_S1_OUT7      16'h0092
`define A_S2_OUT7_HI   16'h0093
`define A_S2_OUT7_LO   16'h0094
`define A_FRAC_OUT2_B3 16'h0095
`define A_FRAC_OUT2_B2 16'h0096
`define A_FRAC_OUT2_B1 16'h0097
`define A_FRAC_OUT2_B0 16'h0098
`define A_FRAC_OUT3_B3 16'h0099
`define A_FRAC_OUT3_B2 16'h009A
`define A_FRAC_OUT3_B1 16'h009B
`define A_FRAC_OUT3_B0 16'h009C

// Field positions inside a driver style byte
`define F_HI_STYLE_MSB 7
`define F_HI_STYLE_LSB 5
`define F_HI_PHASE     4
`define F_LO_STYLE_MSB 3
`define F_LO_STYLE_LSB 1
`define F_LO_PHASE     0

// Reset values
`define RST_OUT_EN     8'h00
`define RST_POLARITY   8'h00
`define RST_STYLE      3'h1
`define RST_PHASE      1'h0
`define RST_S1_CODE    2'h2
`define RST_S2_HALF    16'h0002
`define RST_INT_PART   18'h00008
`define RST_FRAC_PART  28'h0000000

`endif

/* common/output_driver_divider_pkg.sv */
package output_driver_divider_pkg;

  typedef enum logic [2:0] {
    STYLE_HIZ    = 3'h0,
    STYLE_LVPECL = 3'h1,
    STYLE_LVDS   = 3'h2,
    STYLE_LVCMOS = 3'h3,
    STYLE_HCSL   = 3'h4
  } drv_style_t;

  typedef struct packed {
    logic [7:0]        output_enable_bits;
    logic [7:0]        polarity_invert_bits;
    logic [7:0][2:0]   driver_style_select;
    logic [7:0]        single_ended_phase_select;
    logic [7:0][1:0]   first_stage_ratio_code;
    logic [7:0][15:0]  second_stage_half_ratio;
    logic [1:0][17:0]  fractional_output_integer_part;
    logic [1:0][27:0]  fractional_output_fraction_part;
    logic [7:0]        rdata;
    logic [7:0]        leg_drive;
    drv_style_t [7:0]  style;
    logic [7:0]        true_invert;
    logic [7:0]        comp_invert;
    logic [7:0][2:0]   first_ratio;
    logic [7:0]        first_stop;
    logic [7:0][16:0]  second_ratio;
    logic [7:0]        second_bypass;
    logic [1:0][18:0]  int_ratio;
    logic [1:0][28:0]  frac_ratio;
    logic [1:0]        int_illegal;
  } bank_state_t;

endpackage : output_driver_divider_pkg

/* rtl/pair_leg_control.sv */
`timescale 1ns/1ps
module pair_leg_control (
  // Settings of one pair
  input  wire logic                             enable_i,
  input  wire logic                             invert_i,
  input  wire logic [2:0]                       style_i,
  input  wire logic                             phase_i,
  // Decoded leg control
  output logic                                  leg_drive_o,
  output output_driver_divider_pkg::drv_style_t style_o,
  output logic                                  true_invert_o,
  output logic                                  comp_invert_o
);

  always_comb begin
    unique case (style_i)
      3'h0: style_o = output_driver_divider_pkg::STYLE_HIZ;    // [R4]
      3'h1: style_o = output_driver_divider_pkg::STYLE_LVPECL; // [R4]
      3'h2: style_o = output_driver_divider_pkg::STYLE_LVDS;   // [R4]
      3'h3: style_o = output_driver_divider_pkg::STYLE_LVCMOS; // [R4]
      3'h4: style_o = output_driver_divider_pkg::STYLE_HCSL;   // [R4]
      // Reserved codes park the pair rather than guess a level
      default: style_o = output_driver_divider_pkg::STYLE_HIZ; // [R4]
    endcase
    leg_drive_o   = enable_i &&
                    style_o != output_driver_divider_pkg::STYLE_HIZ; // [R1]
    true_invert_o = invert_i; // [R3]
    // Differential styles always run the legs in opposite phase
    comp_invert_o = ~invert_i;
    if (style_o == output_driver_divider_pkg::STYLE_LVCMOS && phase_i) begin
      comp_invert_o = invert_i; // [R5]
    end
  end

endmodule : pair_leg_control

/* rtl/stage_ratio_decode.sv */
`timescale 1ns/1ps
module stage_ratio_decode #(
  parameter bit CODE3_BYPASS = 1'b1
) (
  // Programmed fields
  input  wire logic [1:0]  code_i,
  input  wire logic [15:0] half_i,
  // Effective ratios
  output logic [2:0]       first_ratio_o,
  output logic             first_stop_o,
  output logic [16:0]      second_ratio_o,
  output logic             second_bypass_o
);

  always_comb begin
    first_stop_o = 1'b0;
    unique case (code_i)
      2'h0: first_ratio_o = 3'h5; // [R9]
      2'h1: first_ratio_o = 3'h6; // [R9]
      2'h2: first_ratio_o = 3'h4; // [R9]
      2'h3: begin
        first_ratio_o = CODE3_BYPASS ? 3'h1 : 3'h0; // [R9]
        first_stop_o  = ~CODE3_BYPASS;               // [R9]
      end
    endcase
    second_ratio_o  = {half_i, 1'b0};  // [R10]
    second_bypass_o = (half_i == 16'h0000); // [R10]
  end

endmodule : stage_ratio_decode

/* rtl/output_driver_divider_config.sv */
`timescale 1ns/1ps
`include "output_driver_divider_regs.svh"

// How it works
// (R1) Clear enable bit puts pair in high impedance; set drives chosen style.
// (R2) Enables reset to zero, styles to LVPECL, phase bits to zero.
// (R3) Polarity bit per pair: zero normal, one inverted; resets to zero.
// (R4) Style code: 0 hi-z, 1 LVPECL, 2 LVDS, 3 LVCMOS, 4 HCSL; rest reserved.
// (R5) LVCMOS: phase bit clear gives opposite legs, set gives legs in phase.
// (R6) Software keeps phase bit zero for LVDS, HCSL and LVPECL styles.
// (R7) Style bytes hold two pairs, higher pair in upper nibble, 7/6 first.
// (R8) Ratios stored most significant byte first, lowest address first.
// (R9) First stage: 00 /5, 01 /6, 10 /4; 11 stops 0,1, bypasses 4-7.
// (R10) Second stage divides by twice its value; zero bypasses it.
// (R11) Fractional outputs: ratio twice integer field; 0..2 forbidden.
// (R12) Software writes zero to reserved bits, ignores their read value.
module output_driver_divider_config (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             nrst_i,
  // Byte register port
  input  wire logic [15:0]                      reg_addr_i,
  input  wire logic                             reg_wr_i,
  input  wire logic [7:0]                       reg_wdata_i,
  output logic [7:0]                            reg_rdata_o,
  // Output pair control
  output logic [7:0]                            leg_drive_o,
  output output_driver_divider_pkg::drv_style_t [7:0] style_o,
  output logic [7:0]                            true_invert_o,
  output logic [7:0]                            comp_invert_o,
  // Integer divider outputs
  output logic [7:0][2:0]                       first_ratio_o,
  output logic [7:0]                            first_stop_o,
  output logic [7:0][16:0]                      second_ratio_o,
  output logic [7:0]                            second_bypass_o,
  // Fractional divider outputs 2 and 3
  output logic [1:0][18:0]                      int_ratio_o,
  output logic [1:0][28:0]                      frac_ratio_o,
  output logic [1:0]                            int_illegal_o
);

  output_driver_divider_pkg::bank_state_t s_r;
  output_driver_divider_pkg::bank_state_t s_nxt;

  logic [7:0]                                  dec_drive;
  output_driver_divider_pkg::drv_style_t [7:0] dec_style;
  logic [7:0]                                  dec_tinv;
  logic [7:0]                                  dec_cinv;
  logic [7:0][2:0]                             dec_first;
  logic [7:0]                                  dec_stop;
  logic [7:0][16:0]                            dec_second;
  logic [7:0]                                  dec_bypass;

  generate
    for (genvar g = 0; g < 8; g++) begin : g_pair
      pair_leg_control u_leg (
        .enable_i      (s_r.output_enable_bits[g]),
        .invert_i      (s_r.polarity_invert_bits[g]),
        .style_i       (s_r.driver_style_select[g]),
        .phase_i       (s_r.single_ended_phase_select[g]),
        .leg_drive_o   (dec_drive[g]),
        .style_o       (dec_style[g]),
        .true_invert_o (dec_tinv[g]),
        .comp_invert_o (dec_cinv[g])
      );
      // Outputs 0 and 1 stop on code 11, the others bypass
      stage_ratio_decode #(
        .CODE3_BYPASS ((g > 1) ? 1'b1 : 1'b0)
      ) u_ratio (
        .code_i          (s_r.first_stage_ratio_code[g]),
        .half_i          (s_r.second_stage_half_ratio[g]),
        .first_ratio_o   (dec_first[g]),
        .first_stop_o    (dec_stop[g]),
        .second_ratio_o  (dec_second[g]),
        .second_bypass_o (dec_bypass[g])
      );
    end
  endgenerate

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;
    unique case (reg_addr_i)
      `A_OUT_EN: begin
        s_nxt.rdata = s_r.output_enable_bits;
        if (reg_wr_i) s_nxt.output_enable_bits = reg_wdata_i; // [R1]
      end
      `A_POLARITY: begin
        s_nxt.rdata = s_r.polarity_invert_bits;
        if (reg_wr_i) s_nxt.polarity_invert_bits = reg_wdata_i; // [R3]
      end
      `A_STYLE_76, `A_STYLE_54, `A_STYLE_32, `A_STYLE_10: begin
        for (int p = 0; p < 4; p++) begin
          // Byte 0x79 carries pairs 7/6, 0x7C carries 1/0
          if (reg_addr_i[2:0] == 3'(1 + p)) begin
            s_nxt.rdata = {s_r.driver_style_select[7 - 2 * p],
                           s_r.single_ended_phase_select[7 - 2 * p],
                           s_r.driver_style_select[6 - 2 * p],
                           s_r.single_ended_phase_select[6 - 2 * p]}; // [R7]
            if (reg_wr_i) begin
              s_nxt.driver_style_select[7 - 2 * p] =
                reg_wdata_i[`F_HI_STYLE_MSB:`F_HI_STYLE_LSB]; // [R7]
              s_nxt.single_ended_phase_select[7 - 2 * p] =
                reg_wdata_i[`F_HI_PHASE]; // [R7]
              s_nxt.driver_style_select[6 - 2 * p] =
                reg_wdata_i[`F_LO_STYLE_MSB:`F_LO_STYLE_LSB]; // [R7]
              s_nxt.single_ended_phase_select[6 - 2 * p] =
                reg_wdata_i[`F_LO_PHASE]; // [R7]
            end
          end
        end
      end
      // Reserved bits read zero and drop writes
      `A_S1_OUT0: begin
        s_nxt.rdata = {6'h00, s_r.first_stage_ratio_code[0]};
        if (reg_wr_i) s_nxt.first_stage_ratio_code[0] = reg_wdata_i[1:0];
      end
      `A_S2_OUT0_HI: begin
        s_nxt.rdata = s_r.second_stage_half_ratio[0][15:8]; // [R8]
        if (reg_wr_i) s_nxt.second_stage_half_ratio[0][15:8] = reg_wdata_i;
      end
      `A_S2_OUT0_LO: begin
        s_nxt.rdata = s_r.second_stage_half_ratio[0][7:0];
        if (reg_wr_i) s_nxt.second_stage_half_ratio[0][7:0] = reg_wdata_i;
      end
      `A_S1_OUT1: begin
        s_nxt.rdata = {6'h00, s_r.first_stage_ratio_code[1]};
        if (reg_wr_i) s_nxt.first_stage_ratio_code[1] = reg_wdata_i[1:0];
      end
      `A_S2_OUT1_HI: begin
        s_nxt.rdata = s_r.second_stage_half_ratio[1][15:8];
        if (reg_wr_i) s_nxt.second_stage_half_ratio[1][15:8] = reg_wdata_i;
      end
      `A_S2_OUT1_LO: begin
        s_nxt.rdata = s_r.second_stage_half_ratio[1][7:0];
        if (reg_wr_i) s_nxt.second_stage_half_ratio[1][7:0] = reg_wdata_i;
      end
      `A_INT_OUT2_TOP, `A_INT_OUT3_TOP: begin
        s_nxt.rdata = {6'h00,
          s_r.fractional_output_integer_part[reg_addr_i[2]][17:16]}; // [R8]
        if (reg_wr_i) s_nxt.fractional_output_integer_part
          [reg_addr_i[2]][17:16] = reg_wdata_i[1:0];
      end
      `A_INT_OUT2_MID: begin
        s_nxt.rdata = s_r.fractional_output_integer_part[0][15:8];
        if (reg_wr_i)
          s_nxt.fractional_output_integer_part[0][15:8] = reg_wdata_i;
      end
      `A_INT_OUT2_LOW: begin
        s_nxt.rdata = s_r.fractional_output_integer_part[0][7:0];
        if (reg_wr_i)
          s_nxt.fractional_output_integer_part[0][7:0] = reg_wdata_i;
      end
      `A_INT_OUT3_MID: begin
        s_nxt.rdata = s_r.fractional_output_integer_part[1][15:8];
        if (reg_wr_i)
          s_nxt.fractional_output_integer_part[1][15:8] = reg_wdata_i;
      end
      `A_INT_OUT3_LOW: begin
        s_nxt.rdata = s_r.fractional_output_integer_part[1][7:0];
        if (reg_wr_i)
          s_nxt.fractional_output_integer_part[1][7:0] = reg_wdata_i;
      end
      `A_S1_OUT4, `A_S1_OUT5, `A_S1_OUT6, `A_S1_OUT7,
      `A_S2_OUT4_HI, `A_S2_OUT5_HI, `A_S2_OUT6_HI, `A_S2_OUT7_HI,
      `A_S2_OUT4_LO, `A_S2_OUT5_LO, `A_S2_OUT6_LO, `A_S2_OUT7_LO: begin
        // Outputs 4-7 sit in three-byte groups from 0x89 upward
        for (int q = 4; q < 8; q++) begin
          if (reg_addr_i == `A_S1_OUT4 + 16'(3 * (q - 4))) begin
            s_nxt.rdata = {6'h00, s_r.first_stage_ratio_code[q]};
            if (reg_wr_i) s_nxt.first_stage_ratio_code[q] = reg_wdata_i[1:0];
          end
          if (reg_addr_i == `A_S2_OUT4_HI + 16'(3 * (q - 4))) begin
            s_nxt.rdata = s_r.second_stage_half_ratio[q][15:8]; // [R8]
            if (reg_wr_i)
              s_nxt.second_stage_half_ratio[q][15:8] = reg_wdata_i;
          end
          if (reg_addr_i == `A_S2_OUT4_LO + 16'(3 * (q - 4))) begin
            s_nxt.rdata = s_r.second_stage_half_ratio[q][7:0];
            if (reg_wr_i)
              s_nxt.second_stage_half_ratio[q][7:0] = reg_wdata_i;
          end
        end
      end
      `A_FRAC_OUT2_B3, `A_FRAC_OUT3_B3: begin
        s_nxt.rdata = {4'h0, s_r.fractional_output_fraction_part
          [(reg_addr_i == `A_FRAC_OUT3_B3) ? 1 : 0][27:24]}; // [R8]
        if (reg_wr_i) s_nxt.fractional_output_fraction_part
          [(reg_addr_i == `A_FRAC_OUT3_B3) ? 1 : 0][27:24] =
          reg_wdata_i[3:0];
      end
      `A_FRAC_OUT2_B2, `A_FRAC_OUT2_B1, `A_FRAC_OUT2_B0,
      `A_FRAC_OUT3_B2, `A_FRAC_OUT3_B1, `A_FRAC_OUT3_B0: begin
        for (int f = 0; f < 2; f++) begin
          for (int b = 0; b < 3; b++) begin
            // Lower byte of the fraction sits at the higher address
            if (reg_addr_i == `A_FRAC_OUT2_B0 - 16'(b) + 16'(4 * f)) begin
              s_nxt.rdata =
                s_r.fractional_output_fraction_part[f][8 * b +: 8]; // [R8]
              if (reg_wr_i)
                s_nxt.fractional_output_fraction_part[f][8 * b +: 8] =
                  reg_wdata_i;
            end
          end
        end
      end
      default: s_nxt.rdata = 8'h00;
    endcase

    s_nxt.leg_drive     = dec_drive;  // [R1]
    s_nxt.style         = dec_style;  // [R4]
    s_nxt.true_invert   = dec_tinv;   // [R3]
    s_nxt.comp_invert   = dec_cinv;   // [R5]
    s_nxt.first_ratio   = dec_first;  // [R9]
    s_nxt.first_stop    = dec_stop;   // [R9]
    s_nxt.second_ratio  = dec_second; // [R10]
    s_nxt.second_bypass = dec_bypass; // [R10]
    for (int k = 0; k < 2; k++) begin
      s_nxt.int_ratio[k] =
        {s_r.fractional_output_integer_part[k], 1'b0}; // [R11]
      s_nxt.frac_ratio[k] =
        {s_r.fractional_output_fraction_part[k], 1'b0}; // [R11]
      // Flags a forbidden value; the divider hardware is not protected
      s_nxt.int_illegal[k] =
        (s_r.fractional_output_integer_part[k] < 18'h00003); // [R11]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r                                 <= '0;
      s_r.output_enable_bits              <= `RST_OUT_EN; // [R2]
      s_r.polarity_invert_bits            <= `RST_POLARITY; // [R3]
      s_r.driver_style_select             <= {8{`RST_STYLE}}; // [R2]
      s_r.single_ended_phase_select       <= {8{`RST_PHASE}}; // [R2]
      s_r.first_stage_ratio_code          <= {8{`RST_S1_CODE}};
      s_r.second_stage_half_ratio         <= {8{`RST_S2_HALF}};
      s_r.fractional_output_integer_part  <= {2{`RST_INT_PART}};
      s_r.fractional_output_fraction_part <= {2{`RST_FRAC_PART}};
      s_r.style <= '{default: output_driver_divider_pkg::STYLE_LVPECL};
      s_r.comp_invert                     <= 8'hFF;
      s_r.first_ratio                     <= {8{3'h4}};
      s_r.second_ratio                    <= {8{17'h00004}};
      s_r.int_ratio                       <= {2{19'h00010}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o     = s_r.rdata;
  assign leg_drive_o     = s_r.leg_drive;
  assign style_o         = s_r.style;
  assign true_invert_o   = s_r.true_invert;
  assign comp_invert_o   = s_r.comp_invert;
  assign first_ratio_o   = s_r.first_ratio;
  assign first_stop_o    = s_r.first_stop;
  assign second_ratio_o  = s_r.second_ratio;
  assign second_bypass_o = s_r.second_bypass;
  assign int_ratio_o     = s_r.int_ratio;
  assign frac_ratio_o    = s_r.frac_ratio;
  assign int_illegal_o   = s_r.int_illegal;

endmodule : output_driver_divider_config

/* sim/output_driver_divider_config_monitor.sv */
`timescale 1ns/1ps
module output_driver_divider_config_monitor (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  // Byte register port
  input wire logic [15:0]           reg_addr_i,
  input wire logic                  reg_wr_i,
  input wire logic [7:0]            reg_wdata_i,
  input wire logic [7:0]            reg_rdata_o,
  // Pair control
  input wire logic [7:0]            leg_drive_o,
  input wire output_driver_divider_pkg::drv_style_t [7:0] style_o,
  input wire logic [7:0]            true_invert_o,
  input wire logic [7:0]            comp_invert_o,
  // Divider ratios
  input wire logic [7:0][2:0]       first_ratio_o,
  input wire logic [7:0]            first_stop_o,
  input wire logic [7:0][16:0]      second_ratio_o,
  input wire logic [7:0]            second_bypass_o,
  input wire logic [1:0][18:0]      int_ratio_o,
  input wire logic [1:0][28:0]      frac_ratio_o,
  input wire logic [1:0]            int_illegal_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic leg_ok;
  logic style_ok;
  logic half_ok;

  // Per pair checks folded into flags to keep one assertion per rule
  always_comb begin
    leg_ok   = 1'b1;
    style_ok = 1'b1;
    half_ok  = 1'b1;
    for (int g = 0; g < 8; g++) begin
      if (leg_drive_o[g] && 3'(style_o[g]) == 3'h0) leg_ok = 1'b0;
      if (3'(style_o[g]) > 3'h4) style_ok = 1'b0;
      if (second_bypass_o[g] != (second_ratio_o[g] == 17'h0)) half_ok = 1'b0;
      if (second_ratio_o[g][0]) half_ok = 1'b0;
    end
  end

  property p_leg; leg_ok; endproperty
  a_leg: assert property (p_leg) else $error("pair driven in hi-z");
  property p_reset;
    $rose(nrst_i) |-> leg_drive_o == 8'h00 && comp_invert_o == 8'hFF
      && first_ratio_o == {8{3'h4}};
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset outputs");
  property p_pol;
    reg_wr_i && reg_addr_i == 16'h0078
      |-> ##2 true_invert_o == $past(reg_wdata_i, 2);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not applied");
  property p_style; style_ok; endproperty
  a_style: assert property (p_style) else $error("style out of range");
  property p_pack;
    reg_wr_i && reg_addr_i == 16'h0079 && reg_wdata_i == 8'h48
      |-> ##2 3'(style_o[7]) == 3'h2 && 3'(style_o[6]) == 3'h4;
  endproperty
  a_pack: assert property (p_pack) else $error("style byte packing");
  property p_stop;
    first_stop_o[7:2] == 6'h0 && (!first_stop_o[0] || first_ratio_o[0] == 3'h0)
      && (!first_stop_o[1] || first_ratio_o[1] == 3'h0);
  endproperty
  a_stop: assert property (p_stop) else $error("stop decode wrong");
  property p_code3;
    reg_wr_i && reg_addr_i == 16'h0089 && reg_wdata_i[1:0] == 2'h3
      |-> ##2 first_ratio_o[4] == 3'h1 && !first_stop_o[4];
  endproperty
  a_code3: assert property (p_code3) else $error("code 3 not bypass");
  property p_half; half_ok; endproperty
  a_half: assert property (p_half) else $error("second stage wrong");
  property p_int;
    int_illegal_o[0] == (int_ratio_o[0] <= 19'h4) && !int_ratio_o[0][0]
      && int_illegal_o[1] == (int_ratio_o[1] <= 19'h4) && !frac_ratio_o[1][0];
  endproperty
  a_int: assert property (p_int) else $error("integer part wrong");
  property p_unmapped;
    reg_addr_i == 16'h0080 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad read");
endmodule : output_driver_divider_config_monitor

bind output_driver_divider_config output_driver_divider_config_monitor u_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .leg_drive_o(leg_drive_o), .style_o(style_o),
  .true_invert_o(true_invert_o), .comp_invert_o(comp_invert_o),
  .first_ratio_o(first_ratio_o), .first_stop_o(first_stop_o),
  .second_ratio_o(second_ratio_o), .second_bypass_o(second_bypass_o),
  .int_ratio_o(int_ratio_o), .frac_ratio_o(frac_ratio_o),
  .int_illegal_o(int_illegal_o));

/* sim/output_driver_divider_config_bench.sv */
`timescale 1ns/1ps
`include "output_driver_divider_regs.svh"
module output_driver_divider_config_bench;
  logic        clk_i;
  logic        nrst_i;
  logic [15:0] reg_addr_i;
  logic        reg_wr_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  leg_drive_o;
  output_driver_divider_pkg::drv_style_t [7:0] style_o;
  logic [7:0]  true_invert_o;
  logic [7:0]  comp_invert_o;
  logic [7:0][2:0]  first_ratio_o;
  logic [7:0]  first_stop_o;
  logic [7:0][16:0] second_ratio_o;
  logic [7:0]  second_bypass_o;
  logic [1:0][18:0] int_ratio_o;
  logic [1:0][28:0] frac_ratio_o;
  logic [1:0]  int_illegal_o;
  int          miscompares;
  int          cmp_count;
  logic [15:0] s1a [6] = '{`A_S1_OUT0, `A_S1_OUT1, `A_S1_OUT4, `A_S1_OUT5,
                          `A_S1_OUT6, `A_S1_OUT7};
  logic [15:0] s2a [6] = '{`A_S2_OUT0_HI, `A_S2_OUT1_HI, `A_S2_OUT4_HI,
                          `A_S2_OUT5_HI, `A_S2_OUT6_HI, `A_S2_OUT7_HI};
  logic [8:0]  r1 [4] = '{9'h16D, 9'h1B6, 9'h124, 9'h040};
  logic [15:0] s2v [4] = '{16'h1234, 16'hFFFF, 16'h0000, 16'h0001};
  logic [17:0] iv [4] = '{18'h3FFFF, 18'h00002, 18'h00003, 18'h00000};

  output_driver_divider_config u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .leg_drive_o(leg_drive_o), .style_o(style_o),
    .true_invert_o(true_invert_o), .comp_invert_o(comp_invert_o),
    .first_ratio_o(first_ratio_o), .first_stop_o(first_stop_o),
    .second_ratio_o(second_ratio_o), .second_bypass_o(second_bypass_o),
    .int_ratio_o(int_ratio_o), .frac_ratio_o(frac_ratio_o),
    .int_illegal_o(int_illegal_o));

  function automatic logic [2:0] sty(input int c);
    // Reserved codes decode as hi-z
    sty = ((c % 8) < 5) ? 3'(c % 8) : 3'h0;
  endfunction : sty

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_out(input logic [159:0] got, input logic [159:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  // Each write leaves an idle cycle so the strobe never toggles twice
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    #1;
    chk_byte(reg_rdata_o, e);
  endtask : rd

  // Decoded outputs land one edge after the write edge
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, miscompares);
  endtask : done

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run is well under two thousand cycles
  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  initial begin
    nrst_i      = 1'b0;
    reg_addr_i  = 16'h0000;
    reg_wr_i    = 1'b0;
    reg_wdata_i = 8'h00;
    miscompares = 0;
    cmp_count   = 0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`A_OUT_EN, 8'h00);
    rd(`A_POLARITY, 8'h00);
    for (int i = 0; i < 4; i++) rd(`A_STYLE_76 + 16'(i), 8'h22);
    foreach (s1a[i]) begin
      rd(s1a[i], 8'h02);
      rd(s2a[i], 8'h00);
      rd(s2a[i] + 16'h1, 8'h02);
    end
    for (int k = 0; k < 2; k++) begin
      rd(`A_INT_OUT2_TOP + 16'(3 * k), 8'h00);
      rd(`A_INT_OUT2_MID + 16'(3 * k), 8'h00);
      rd(`A_INT_OUT2_LOW + 16'(3 * k), 8'h08);
    end
    for (int i = 0; i < 8; i++) rd(`A_FRAC_OUT2_B3 + 16'(i), 8'h00);
    chk_out(160'({leg_drive_o, true_invert_o, comp_invert_o}),
            160'hFF);
    chk_out(160'({style_o, first_ratio_o}), 160'h249249_924924);
    chk_out(160'(second_ratio_o), 160'({8{17'h00004}}));
    chk_out(160'(int_ratio_o), 160'({2{19'h00010}}));
    chk_out(160'({first_stop_o, second_bypass_o, int_illegal_o}),
            160'h0);
    done("reset");
    wr(`A_OUT_EN, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      wr(`A_STYLE_10, {3'(c), 1'b0, 3'(c), 1'b0});
      wr(`A_STYLE_76, {3'(c), 1'b0, 3'(c + 2), 1'b0});
      settle();
      chk_out(160'({style_o[1], style_o[0], style_o[7]}),
              160'({sty(c), sty(c), sty(c)}));
      chk_out(160'(style_o[6]), 160'(sty(c + 2)));
      chk_out(160'(leg_drive_o[0]), 160'(sty(c) != 3'h0));
    end
    chk_out(160'(leg_drive_o), 160'h7C);
    wr(`A_OUT_EN, 8'h00);
    settle();
    chk_out(160'(leg_drive_o), 160'h0);
    done("styles");
    wr(`A_STYLE_10, 8'h76);
    wr(`A_STYLE_32, 8'h44);
    for (int p = 0; p < 4; p++) begin
      wr(`A_POLARITY, 8'(p));
      settle();
      chk_out(160'(true_invert_o), 160'(p));
      chk_out(160'(comp_invert_o[3:0]), 160'({2'b11, p[1], ~p[0]}));
    end
    done("polarity");
    for (int c = 0; c < 4; c++) begin
      wr(`A_S1_OUT0, 8'(c));
      wr(`A_S1_OUT1, 8'(c));
      wr(`A_S1_OUT4, 8'(c));
      settle();
      chk_out(160'({first_ratio_o[4], first_ratio_o[1], first_ratio_o[0]}),
              160'(r1[c]));
      chk_out(160'(first_stop_o), 160'((c == 3) ? 8'h03 : 8'h00));
    end
    done("first stage");
    foreach (s2v[i]) begin
      wr(`A_S2_OUT4_HI, s2v[i][15:8]);
      wr(`A_S2_OUT4_LO, s2v[i][7:0]);
      settle();
      chk_out(160'(second_ratio_o[4]), 160'({s2v[i], 1'b0}));
      chk_out(160'(second_bypass_o),
              160'(s2v[i] == 16'h0 ? 8'h10 : 8'h0));
      rd(`A_S2_OUT4_HI, s2v[i][15:8]);
    end
    done("second stage");
    foreach (iv[i]) begin
      wr(`A_INT_OUT2_TOP, 8'(iv[i][17:16]));
      wr(`A_INT_OUT2_MID, iv[i][15:8]);
      wr(`A_INT_OUT2_LOW, iv[i][7:0]);
      settle();
      chk_out(160'(int_ratio_o[0]), 160'({iv[i], 1'b0}));
      chk_out(160'(int_illegal_o[0]), 160'(iv[i] < 18'h3));
    end
    wr(`A_FRAC_OUT3_B3, 8'h0F);
    wr(`A_FRAC_OUT3_B2, 8'hAB);
    wr(`A_FRAC_OUT3_B1, 8'hCD);
    wr(`A_FRAC_OUT3_B0, 8'hEF);
    settle();
    chk_out(160'(frac_ratio_o), 160'({29'h1F579BDE, 29'h0}));
    rd(`A_FRAC_OUT3_B3, 8'h0F);
    done("fractional");
    wr(16'h0080, 8'hFF);
    rd(16'h0080, 8'h00);
    wr(`A_S1_OUT0, 8'h03);
    rd(`A_S1_OUT0, 8'h03);
    wr(`A_INT_OUT3_TOP, 8'h03);
    rd(`A_INT_OUT3_TOP, 8'h03);
    done("reserved");
    summarize();
  end
endmodule : output_driver_divider_config_bench
